// file: ebs_consts.svh
// Purpose: Constants for the external bus strobe controller
// Assumes: 20 MHz aclk, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit registers
`ifndef EBS_CONSTS_SVH
`define EBS_CONSTS_SVH
`define EBS_OFS_CFG 12'h000
`define EBS_OFS_CMD 12'h004
`define EBS_OFS_STAT 12'h008
`define EBS_OFS_RDATA 12'h00c
// Configuration register fields
`define EBS_CFG_BUS_ACTIVE_BITS_LO 0
`define EBS_CFG_BUS_TYPE_FIELD_LO 4
`define EBS_CFG_SHOW_BIT 6
`define EBS_CFG_SPLITWR_BIT 7
`define EBS_CFG_RDYEN_BIT 8
`define EBS_CFG_RDYASYNC_BIT 9
`define EBS_CFG_WAIT_LO 12
`define EBS_CFG_RESET 32'h0000_0000
// Command register fields
`define EBS_CMD_WDATA_LO 0
`define EBS_CMD_KIND_LO 16
`define EBS_CMD_WRITE_BIT 18
`define EBS_CMD_HIGH_BIT 19
`define EBS_CMD_LOW_BIT 20
// Phase lengths in aclk cycles
`define EBS_ALE_CYC 4'h1
`define EBS_ADDR_HOLD_CYC 4'h1
`define EBS_CMD_CYC 4'h2
`endif

// file: ebs_pkg.sv
// Purpose: Types for the external bus strobe controller
// Assumes: Nothing beyond the consts header
// Notes: Access kinds come from the command register
package ebs_pkg;
    typedef enum logic [1:0] {
        EBS_ACC_EXT = 2'h0,
        EBS_ACC_XPER = 2'h1,
        EBS_ACC_INT = 2'h2
    } ebs_acc_type;
    typedef enum logic [2:0] {
        EBS_IDLE = 3'h0,
        EBS_ALE = 3'h1,
        EBS_ADDR = 3'h3,
        EBS_CMD = 3'h2,
        EBS_DONE = 3'h6
    } ebs_state_type;
endpackage : ebs_pkg

// file: ebs_ready_if.sv
// Purpose: Carrier between core and ready sampler
// Assumes: Single aclk domain
// Notes: Sampler output is already synchronised
interface ebs_ready_if;
    logic async_mode;
    logic ready_seen;
    modport core (output async_mode, input ready_seen);
    modport smp (input async_mode, output ready_seen);
endinterface : ebs_ready_if

// file: ebs_ready_smp.sv
// Purpose: Ready pin sampler, synchronous or asynchronous evaluation
// Assumes: Pin is outside the aclk domain
// Notes: Async mode adds one extra sampling stage
module ebs_ready_smp
    import ebs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ready_n_pin,
    ebs_ready_if.smp rif
);
    logic s1_r, s2_r, s3_r;
    logic s1_nxt, s2_nxt, s3_nxt;
    always_comb begin
        s1_nxt = ready_n_pin;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end
    // Async needs a stable second sample to reject a mid-edge glitch
    assign rif.ready_seen = rif.async_mode ? (!s2_r && !s3_r) : !s2_r;
endmodule : ebs_ready_smp

// file: ebs_strobe_ctrl.sv
// Purpose: Control strobes of an external bus: ale, read, write low/high
// Assumes: Command is issued by software over AXI4-Lite
// Notes: One bus cycle at a time; busy commands are dropped
// Function
// - Bus enabled: ale pulses for extra peripherals
// - No ale for internal ram or registers
// - No active bus: no ale at all
// - Read strobe enables external drivers on reads
// - Read strobe high in reset and hold
// - Write strobe high in reset and hold
// - Write pin: common or low-byte with high
// - Ready ends cycle when enabled
// - Ready evaluated synchronously or asynchronously
// - Ready ignored during programmed waitstates
// - Show bit gates command strobes for extra peripherals
// - Access pin picks internal or external boot
// - Bus usable only when active, whatever its type
// - Read latches data; write data held
`include "ebs_consts.svh"
module ebs_strobe_ctrl
    import ebs_pkg::*;
#(
    parameter int WAIT_W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic hold_req,
    input wire logic ext_access_sel_n,
    input wire logic ready_n,
    input wire logic [15:0] data_in,
    output logic ale,
    output logic read_strobe_n,
    output logic write_low_strobe_n,
    output logic write_high_strobe_n,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic boot_external
);
    ebs_ready_if rif ();
    logic [1:0] hold_s_r, ea_s_r;
    logic [31:0] cfg_r, cfg_nxt;
    logic [15:0] rdat_r, rdat_nxt, wdat_r, wdat_nxt;
    ebs_state_type st_r, st_nxt;
    ebs_acc_type kind_r, kind_nxt;
    logic wr_r, wr_nxt, hi_r, hi_nxt, lo_r, lo_nxt, vis_r, vis_nxt;
    localparam int CNT_W = WAIT_W + 1;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic ale_nxt, rd_nxt, wl_nxt, wh_nxt, oe_nxt, boot_r, boot_nxt, boot_done_r;
    logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bv_nxt, rv_nxt;
    logic [11:0] awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rd_data_nxt;
    logic [1:0] br_nxt, rr_nxt;
    logic cmd_go;
    ebs_ready_smp u_smp (
        .aclk(aclk),
        .aresetn(aresetn),
        .ready_n_pin(ready_n),
        .rif(rif)
    );
    assign rif.async_mode = cfg_r[`EBS_CFG_RDYASYNC_BIT];

    function automatic logic bus_on(input logic [31:0] c);
        // Bus only usable with an active bit set
        return |c[`EBS_CFG_BUS_ACTIVE_BITS_LO +: 4];
    endfunction : bus_on
    function automatic logic [2:0] cmd_levels(input logic [31:0] c, input logic v, w, h, l);
        // Common strobe vs low byte and high byte pair
        return {!(v && !w), !(v && w && (!c[`EBS_CFG_SPLITWR_BIT] || l)),
                !(v && w && c[`EBS_CFG_SPLITWR_BIT] && h)};
    endfunction : cmd_levels

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_s_r <= 2'h0;
        end else begin
            hold_s_r <= {hold_s_r[0], hold_req};
        end
        // Sampled under reset too, so the boot pick sees the pin at release
        ea_s_r <= {ea_s_r[0], ext_access_sel_n};
    end

    // Register writes: both channels taken in either order
    always_comb begin
        aw_ok_nxt = aw_ok_r;
        w_ok_nxt = w_ok_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        bv_nxt = s_axi_bvalid;
        br_nxt = s_axi_bresp;
        cfg_nxt = cfg_r;
        cmd_go = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_ok_nxt = 1'b1;
            wd_nxt = s_axi_wdata;
        end
        if (aw_ok_r && w_ok_r && !s_axi_bvalid) begin
            aw_ok_nxt = 1'b0;
            w_ok_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = 2'h0;
            case (awa_r)
                `EBS_OFS_CFG: cfg_nxt = wd_r;
                `EBS_OFS_CMD: cmd_go = 1'b1;
                `EBS_OFS_STAT, `EBS_OFS_RDATA: br_nxt = 2'h0;
                default: br_nxt = 2'h2;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bv_nxt = 1'b0;
        end
    end

    always_comb begin
        rv_nxt = s_axi_rvalid;
        rd_data_nxt = s_axi_rdata;
        rr_nxt = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_nxt = 1'b1;
            rr_nxt = 2'h0;
            case (s_axi_araddr)
                `EBS_OFS_CFG: rd_data_nxt = cfg_r;
                `EBS_OFS_STAT: rd_data_nxt = {27'h0, boot_r, st_r == EBS_IDLE ? 1'b0 : 1'b1,
                                              st_r};
                `EBS_OFS_RDATA: rd_data_nxt = {16'h0, rdat_r};
                `EBS_OFS_CMD: rd_data_nxt = 32'h0;
                default: begin
                    rd_data_nxt = 32'h0;
                    rr_nxt = 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
    end

    // Bus cycle sequencer
    always_comb begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        wr_nxt = wr_r;
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        vis_nxt = vis_r;
        cnt_nxt = cnt_r;
        rdat_nxt = rdat_r;
        wdat_nxt = wdat_r;
        oe_nxt = data_oe;
        ale_nxt = 1'b0;
        rd_nxt = 1'b1;
        wl_nxt = 1'b1;
        wh_nxt = 1'b1;
        case (st_r)
            EBS_IDLE: begin
                if (cmd_go && !hold_s_r[1]) begin
                    kind_nxt = ebs_acc_type'(wd_r[`EBS_CMD_KIND_LO +: 2]);
                    wr_nxt = wd_r[`EBS_CMD_WRITE_BIT];
                    hi_nxt = wd_r[`EBS_CMD_HIGH_BIT];
                    lo_nxt = wd_r[`EBS_CMD_LOW_BIT];
                    if (wd_r[`EBS_CMD_WRITE_BIT]) begin
                        wdat_nxt = wd_r[`EBS_CMD_WDATA_LO +: 16];
                    end
                    // Internal targets never reach the pins
                    // External access needs an active bus
                    // Extra peripherals reach the pins only with an active bus
                    if (bus_on(cfg_r) && kind_nxt != EBS_ACC_INT) begin
                        st_nxt = EBS_ALE;
                        ale_nxt = 1'b1;
                        cnt_nxt = CNT_W'(`EBS_ALE_CYC);
                        oe_nxt = 1'b0;
                        // Show bit decides command strobes for peripherals
                        vis_nxt = kind_nxt == EBS_ACC_EXT || cfg_r[`EBS_CFG_SHOW_BIT];
                    end
                end
            end
            EBS_ALE: begin
                // Address is valid at ale fall, latched externally
                st_nxt = EBS_ADDR;
                cnt_nxt = CNT_W'(`EBS_ADDR_HOLD_CYC);
            end
            EBS_ADDR: begin
                st_nxt = EBS_CMD;
                cnt_nxt = CNT_W'(`EBS_CMD_CYC) + CNT_W'(cfg_r[`EBS_CFG_WAIT_LO +: WAIT_W]);
                {rd_nxt, wl_nxt, wh_nxt} = cmd_levels(cfg_r, vis_r, wr_r, hi_r, lo_r);
                if (wr_r) begin
                    oe_nxt = 1'b1;
                end
            end
            EBS_CMD: begin
                {rd_nxt, wl_nxt, wh_nxt} = cmd_levels(cfg_r, vis_r, wr_r, hi_r, lo_r);
                if (cnt_r > CNT_W'(1)) begin
                    // Ready not looked at during waitstates
                    cnt_nxt = cnt_r - CNT_W'(1);
                end else if (!cfg_r[`EBS_CFG_RDYEN_BIT] || rif.ready_seen) begin
                    // Ready ends the cycle
                    st_nxt = EBS_DONE;
                    rd_nxt = 1'b1;
                    wl_nxt = 1'b1;
                    wh_nxt = 1'b1;
                    if (!wr_r) begin
                        rdat_nxt = data_in;
                    end
                end
            end
            EBS_DONE: st_nxt = EBS_IDLE;
            default: st_nxt = EBS_IDLE;
        endcase
        if (hold_s_r[1]) begin
            // Hold forces command strobes idle
            rd_nxt = 1'b1;
            wl_nxt = 1'b1;
            wh_nxt = 1'b1;
            oe_nxt = 1'b0;
        end
    end

    // Boot source caught after reset release, not under reset
    assign boot_nxt = boot_done_r ? boot_r : !ea_s_r[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= `EBS_CFG_RESET;
            st_r <= EBS_IDLE;
            kind_r <= EBS_ACC_INT;
            {wr_r, hi_r, lo_r, vis_r} <= 4'h0;
            cnt_r <= '0;
            rdat_r <= 16'h0;
            wdat_r <= 16'h0;
            ale <= 1'b0;
            read_strobe_n <= 1'b1;
            write_low_strobe_n <= 1'b1;
            write_high_strobe_n <= 1'b1;
            data_oe <= 1'b0;
            boot_r <= 1'b0;
            boot_done_r <= 1'b0;
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            awa_r <= 12'h0;
            wd_r <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            cfg_r <= cfg_nxt;
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            {wr_r, hi_r, lo_r, vis_r} <= {wr_nxt, hi_nxt, lo_nxt, vis_nxt};
            cnt_r <= cnt_nxt;
            rdat_r <= rdat_nxt;
            wdat_r <= wdat_nxt;
            ale <= ale_nxt;
            read_strobe_n <= rd_nxt;
            write_low_strobe_n <= wl_nxt;
            write_high_strobe_n <= wh_nxt;
            data_oe <= oe_nxt;
            boot_r <= boot_nxt;
            boot_done_r <= 1'b1;
            aw_ok_r <= aw_ok_nxt;
            w_ok_r <= w_ok_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            s_axi_bvalid <= bv_nxt;
            s_axi_bresp <= br_nxt;
            s_axi_rvalid <= rv_nxt;
            s_axi_rdata <= rd_data_nxt;
            s_axi_rresp <= rr_nxt;
        end
    end

    // Ready channels registered so outputs come from flip-flops
    logic awr_r, wr_rdy_r, arr_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awr_r <= 1'b0;
            wr_rdy_r <= 1'b0;
            arr_r <= 1'b0;
        end else begin
            awr_r <= !aw_ok_nxt && !(s_axi_awvalid && awr_r);
            wr_rdy_r <= !w_ok_nxt && !(s_axi_wvalid && wr_rdy_r);
            arr_r <= !rv_nxt && !(s_axi_arvalid && arr_r);
        end
    end
    assign s_axi_awready = awr_r;
    assign s_axi_wready = wr_rdy_r;
    assign s_axi_arready = arr_r;
    assign data_out = wdat_r;
    assign boot_external = boot_r;

    chk_ale_needs_bus: assert property (@(posedge aclk) disable iff (!aresetn)
        ale |-> $past(bus_on(cfg_r))) else $error("ale without active bus");
    chk_rd_hold_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(hold_s_r[1]) |-> read_strobe_n) else $error("read strobe in hold");
    chk_wr_hold_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(hold_s_r[1]) |-> write_low_strobe_n && write_high_strobe_n)
        else $error("write strobe in hold");
    chk_ale_before_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(read_strobe_n) |-> $past(ale, 2)) else $error("read without ale");
    chk_int_no_ale: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r == EBS_IDLE && cmd_go && wd_r[`EBS_CMD_KIND_LO +: 2] == 2'h2) |=> !ale)
        else $error("ale on internal access");
    chk_wh_split_only: assert property (@(posedge aclk) disable iff (!aresetn)
        !write_high_strobe_n |-> cfg_r[`EBS_CFG_SPLITWR_BIT]) else $error("high strobe");
    chk_show_gates: assert property (@(posedge aclk) disable iff (!aresetn)
        (!read_strobe_n || !write_low_strobe_n) |-> vis_r)
        else $error("hidden peripheral strobe");
    chk_wait_no_end: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r == EBS_CMD && cnt_r > CNT_W'(1)) |=> st_r == EBS_CMD)
        else $error("cycle ended in waitstate");
endmodule : ebs_strobe_ctrl

// file: ebs_ext_mem.sv
// Purpose: External memory model facing the strobe pins
// Assumes: Command strobes active low, one bus cycle at a time
// Notes: Released data lines show a changing pattern, not the old word
module ebs_ext_mem (
    input wire logic aclk,
    input wire logic ale,
    input wire logic read_strobe_n,
    input wire logic write_low_strobe_n,
    input wire logic write_high_strobe_n,
    input wire logic [15:0] data_out,
    input wire logic [3:0] rdy_dly,
    output logic [15:0] data_in,
    output logic ready_n,
    output logic [15:0] wr_word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    logic cmd_on, ale_q, addr_ok;
    initial begin
        cnt = 4'h0;
        ale_q = 1'b0;
        addr_ok = 1'b0;
        data_in = 16'h0000;
        ready_n = 1'b1;
        wr_word = 16'h0000;
    end
    assign cmd_on = !read_strobe_n || !write_low_strobe_n || !write_high_strobe_n;
    always @(posedge aclk) begin
        cnt <= cmd_on ? cnt + 4'h1 : 4'h0;
        ale_q <= ale;
        // Address taken on the latch strobe fall; no answer without it
        if (ale_q && !ale) begin
            addr_ok <= 1'b1;
        end else if (!cmd_on && cnt != 4'h0) begin
            addr_ok <= 1'b0;
        end
        // Pull-up keeps ready idle high between cycles
        ready_n <= !(cmd_on && addr_ok && cnt >= rdy_dly);
        data_in <= (!read_strobe_n && addr_ok) ? 16'hc3a5 : ~data_in;
        if (cmd_on) begin
            wr_word <= data_out;
        end
    end
endmodule : ebs_ext_mem

// file: testbench.sv
// Purpose: Self-checking bench for the external bus strobe controller
// Assumes: 20 MHz aclk, AXI4-Lite master tasks, memory model on the pins
// Notes: A monitor counts strobe cycles; each bus cycle is judged by deltas
`include "ebs_consts.svh"
module testbench
    import ebs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, hold_req, ext_access_sel_n, ready_n, ale, read_strobe_n;
    logic write_low_strobe_n, write_high_strobe_n, data_oe, boot_external;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_word;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic [15:0] data_in, data_out, wr_word;
    logic [3:0] rdy_dly;
    int err_total, checks, cnt[4], base[4];
    logic [31:0] rcfg[3] = '{32'h101, 32'h8101, 32'h301};
    logic [3:0] rdly[3] = '{4'h6, 4'h0, 4'h6};
    int rlo[3] = '{10, 10, 11};
    ebs_strobe_ctrl ebs_strobe_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .hold_req, .ext_access_sel_n, .ready_n, .data_in, .ale, .read_strobe_n,
        .write_low_strobe_n, .write_high_strobe_n, .data_out, .data_oe, .boot_external);
    ebs_ext_mem ebs_ext_mem_i (.aclk, .ale, .read_strobe_n, .write_low_strobe_n,
        .write_high_strobe_n, .data_out, .rdy_dly, .data_in, .ready_n, .wr_word);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cnt[0] <= cnt[0] + int'(ale);
        cnt[1] <= cnt[1] + int'(!read_strobe_n);
        cnt[2] <= cnt[2] + int'(!write_low_strobe_n);
        cnt[3] <= cnt[3] + int'(!write_high_strobe_n);
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_bvalid) @(posedge aclk);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    // Polls busy so no command is issued over a running bus cycle
    task run_cmd(input logic [31:0] cmd);
        int n;
        base = cnt;
        axi_wr(`EBS_OFS_CMD, cmd);
        rd_word = 32'h8;
        n = 0;
        while (rd_word[3] && n < 100) begin
            axi_rd(`EBS_OFS_STAT, rd_word, rd_resp);
            n++;
        end
        repeat (2) @(posedge aclk);
    endtask : run_cmd
    task chk_cnt(input int a, input int r, input int l, input int h);
        chk(32'(cnt[0] - base[0]), 32'(a));
        chk(32'(cnt[1] - base[1]), 32'(r));
        chk(32'(cnt[2] - base[2]), 32'(l));
        chk(32'(cnt[3] - base[3]), 32'(h));
    endtask : chk_cnt
    task do_reset(input logic sel_n);
        aresetn <= 1'b0;
        ext_access_sel_n <= sel_n;
        repeat (6) @(posedge aclk);
        chk({28'h0, ale, read_strobe_n, write_low_strobe_n, write_high_strobe_n}, 32'h7);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        axi_rd(`EBS_OFS_STAT, rd_word, rd_resp);
        chk({31'h0, rd_word[4]}, {31'h0, ~sel_n});
        chk({31'h0, boot_external}, {31'h0, ~sel_n});
        $display("done reset");
    endtask : do_reset
    task print_verdict;
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #(50 * 20000);
        err_total++;
        print_verdict();
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        {aresetn, hold_req, ext_access_sel_n, rdy_dly} = 7'h00;
        cnt = '{0, 0, 0, 0};
        do_reset(1'b0);
        axi_rd(12'h010, rd_word, rd_resp);
        chk({30'h0, rd_resp}, 32'h2);
        axi_wr(12'h010, 32'h0);
        chk({30'h0, wr_resp}, 32'h2);
        axi_wr(`EBS_OFS_CFG, 32'h1);
        run_cmd(32'h0);
        chk_cnt(1, 2, 0, 0);
        axi_rd(`EBS_OFS_RDATA, rd_word, rd_resp);
        chk(rd_word, 32'hc3a5);
        axi_wr(`EBS_OFS_CFG, 32'h3001);
        run_cmd(32'h0);
        chk_cnt(1, 5, 0, 0);
        run_cmd(32'h20000);
        chk_cnt(0, 0, 0, 0);
        axi_wr(`EBS_OFS_CFG, 32'h1);
        run_cmd(32'h10000);
        chk_cnt(1, 0, 0, 0);
        axi_wr(`EBS_OFS_CFG, 32'h41);
        run_cmd(32'h10000);
        chk_cnt(1, 2, 0, 0);
        axi_wr(`EBS_OFS_CFG, 32'h0);
        run_cmd(32'h0);
        chk_cnt(0, 0, 0, 0);
        run_cmd(32'h10000);
        chk_cnt(0, 0, 0, 0);
        $display("done ale and read");
        axi_wr(`EBS_OFS_CFG, 32'h1);
        run_cmd(32'hc1234);
        chk_cnt(1, 0, 2, 0);
        chk({16'h0, wr_word}, 32'h1234);
        chk({31'h0, data_oe}, 32'h1);
        axi_wr(`EBS_OFS_CFG, 32'h81);
        run_cmd(32'hc1234);
        chk_cnt(1, 0, 0, 2);
        run_cmd(32'h1c5678);
        chk_cnt(1, 0, 2, 2);
        chk({16'h0, data_out}, 32'h5678);
        $display("done writes");
        for (int i = 0; i < 3; i++) begin
            rdy_dly <= rdly[i];
            axi_wr(`EBS_OFS_CFG, rcfg[i]);
            run_cmd(32'h0);
            chk(32'(cnt[1] - base[1]), 32'(rlo[i]));
        end
        rdy_dly <= 4'h0;
        chk({31'h0, data_oe}, 32'h0);
        $display("done ready");
        hold_req <= 1'b1;
        axi_wr(`EBS_OFS_CFG, 32'h41);
        run_cmd(32'h0);
        chk_cnt(0, 0, 0, 0);
        run_cmd(32'h1c1111);
        chk_cnt(0, 0, 0, 0);
        do_reset(1'b1);
        hold_req <= 1'b0;
        $display("done hold");
        print_verdict();
    end
endmodule : testbench
